// *** verilog/phc_pkg.sv ***
// shared constants and types of the pipeline hold and trap control
package phc_pkg;
   // ==========
   // timing
   localparam int TX_W       = 3;
   localparam int NX_W       = 4;
   localparam int CNT_W      = 3;
   // ==========
   // register map
   localparam logic [7:0] REG_CTRL   = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_TRAPS  = 8'h08;
   localparam int CTRL_TRAP_EN  = 0;
   localparam int CTRL_SW_HOLD  = 1;
   localparam logic [1:0] CTRL_RESET = 2'h1;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   localparam logic [7:0] ZERO_BYTE   = 8'h00;
   // ==========
   // microstep sequencer, gray along the usual path
   typedef enum logic [1:0] {
      MS_S7  = 2'h0,
      MS_S8  = 2'h1,
      MS_NX  = 2'h3
   } phc_step_e;
   // ==========
   // stage enables carried together
   typedef struct packed {
      logic latch;
      logic s8;
      logic s7;
      logic s6;
      logic s5;
      logic s4;
      logic s3;
      logic s2;
      logic s1;
   } phc_stage_en_s;
   localparam phc_stage_en_s EN_NONE = '0;
endpackage

// *** verilog/phc_ext_counter.sv ***
// whole-beat down counter for one microstep extension
module phc_ext_counter
   import phc_pkg::*;
#(
   parameter int W = CNT_W
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         ce,
   input  wire logic         load,
   input  wire logic [W-1:0] load_value,
   input  wire logic         dec,
   output logic              finished
);
   logic [W-1:0] count_reg;
   logic [W-1:0] count_next;
   logic         fin_reg;
   logic         fin_next;

   // ==========
   // next state
   always_comb begin
      count_next = count_reg;
      if (load) begin
         count_next = load_value;
      end else if (dec && count_reg != '0) begin
         count_next = count_reg - W'(1);
      end
      fin_next = (count_next == '0);
   end

   // ==========
   // registers; finished is a flop so stage gating sees no glitch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= '0;
         fin_reg   <= 1'b1;
      end else if (ce) begin
         count_reg <= count_next;
         fin_reg   <= fin_next;
      end
   end

   assign finished = fin_reg;
endmodule

// *** verilog/phc_top.sv ***
// pipeline hold and trap control: step timing, holds, fetch traps
// Functional notes
// RQ1: even time extension delays latch and stage-8 clocks in whole beats
// RQ2: odd time extension adds delay in half-beat ticks
// RQ3: whole-beat extensions are down counters, loaded at stage 7
// RQ4: finished stays inactive until the counter reaches zero
// RQ5: odd part delays end-of-beat by one tick during stage 8
// RQ6: storage hold request suppresses every stage enable
// RQ7: storage unit holds from stage 7 while memory controller busy
// RQ8: storage unit holds through a cache miss
// RQ9: storage unit holds one beat for unaligned write
// RQ10: storage unit holds until read data valid arrives
// RQ11: storage unit holds through an unaligned read
// RQ12: storage unit flags fetch trap at stage-2 clock
// RQ13: trapped instruction never reaches execute, except pointer word
// RQ14: earlier fetched instructions finish before a trap is acted on
// RQ15: mispredict recovery overrides a pending fetch trap
// RQ16: trap taken only if still present when re-created
// RQ17: storage unit copies faulting fetch address into address register
// RQ18: fetch traps are taken from the idle microstep only
// RQ19: trap blocks stage 3, and stage 5 for unaligned second word
// RQ20: stage 1 and 2 keep running so the trap is re-latched
// RQ21: jump load of fetch pointer with flush clears a pending trap
// RQ22: storage unit freezes fetch pointer, starts no miss on trap
// RQ23: one tick is half a beat; time 0-6, next 0-8 even
// RQ24: zero extensions: stage 8 four ticks after latch, latch coincides
// RQ25: next extension delays next latch from stage 8
// RQ26: counters and half-beat delay cleared on reset
// RQ27: finished indications are registered
module phc_top
   import phc_pkg::*;
(
   input  wire logic            aclk,
   input  wire logic            aresetn,
   input  wire logic            ce,
   input  wire logic [TX_W-1:0] time_extension,
   input  wire logic [NX_W-1:0] next_step_extension,
   input  wire logic            storage_hold_request,
   input  wire logic            front_end_ready,
   input  wire logic            fetch_trap_flag,
   input  wire logic            trap_on_second_word,
   input  wire logic            address_pointer_word,
   input  wire logic            mispredict_recovery,
   input  wire logic            idle_microstep,
   input  wire logic            trap_still_present,
   input  wire logic            fetch_pointer_jump_load,
   output phc_stage_en_s        stage_en,
   output logic                 end_of_beat_enable,
   output logic                 time_ext_finished,
   output logic                 next_ext_finished,
   output logic                 fetch_trap_take,
   output logic                 execute_pass_ok,
   input  wire logic [7:0]      s_axi_awaddr,
   input  wire logic            s_axi_awvalid,
   output logic                 s_axi_awready,
   input  wire logic [31:0]     s_axi_wdata,
   input  wire logic [3:0]      s_axi_wstrb,
   input  wire logic            s_axi_wvalid,
   output logic                 s_axi_wready,
   output logic [1:0]           s_axi_bresp,
   output logic                 s_axi_bvalid,
   input  wire logic            s_axi_bready,
   input  wire logic [7:0]      s_axi_araddr,
   input  wire logic            s_axi_arvalid,
   output logic                 s_axi_arready,
   output logic [31:0]          s_axi_rdata,
   output logic [1:0]           s_axi_rresp,
   output logic                 s_axi_rvalid,
   input  wire logic            s_axi_rready
);
   // ==========
   // declarations
   phc_step_e     step_reg;
   phc_step_e     step_next;
   logic          phase_reg;
   logic          phase_next;
   logic          half_reg;
   logic          half_next;
   logic          tx_fin;
   logic          nx_fin;
   logic          go;
   logic          eob;
   logic          s7_fire;
   logic          s8_fire;
   logic          latch_fire;
   logic          fe_fire;
   logic          tx_dec;
   logic          nx_dec;
   phc_stage_en_s en_reg;
   phc_stage_en_s en_next;
   logic          eob_reg;
   logic          txf_reg;
   logic          nxf_reg;
   logic          pend_reg;
   logic          pend_next;
   logic          second_reg;
   logic          second_next;
   logic          take_reg;
   logic          take_next;
   logic          pass_reg;
   logic          pass_next;
   logic [1:0]    ctrl_reg;
   logic [1:0]    ctrl_next;
   logic [31:0]   traps_reg;
   logic [31:0]   traps_next;
   logic          awh_reg;
   logic          awh_next;
   logic          wh_reg;
   logic          wh_next;
   logic [7:0]    awa_reg;
   logic [7:0]    awa_next;
   logic [31:0]   wd_reg;
   logic [31:0]   wd_next;
   logic [3:0]    ws_reg;
   logic [3:0]    ws_next;
   logic          bv_reg;
   logic          bv_next;
   logic [1:0]    br_reg;
   logic [1:0]    br_next;
   logic          rv_reg;
   logic          rv_next;
   logic [31:0]   rd_reg;
   logic [31:0]   rd_next;
   logic [1:0]    rr_reg;
   logic [1:0]    rr_next;
   logic          do_write;

   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_TRAPS);
   endfunction

   // ==========
   // beat timing
   // a hold still lets ticks run: it inserts beats, it does not stop time
   assign go  = !storage_hold_request && !ctrl_reg[CTRL_SW_HOLD];  // [RQ6] [RQ7]
   // odd part of the time extension stretches the first stage-8 beat
   assign eob = phase_reg && !(half_reg && step_reg == MS_S8);     // [RQ5] [RQ2]

   always_comb begin
      phase_next = !phase_reg;
      half_next  = half_reg;
      if (phase_reg && half_reg && step_reg == MS_S8) begin
         phase_next = phase_reg; // [RQ2]
         half_next  = 1'b0;
      end
      if (s7_fire) begin
         half_next = time_extension[0]; // [RQ5]
      end
   end

   // ==========
   // microstep sequencer: latch, stage 7, stage 8, next extension
   assign s7_fire    = step_reg == MS_S7 && eob && go;
   assign s8_fire    = step_reg == MS_S8 && eob && go && tx_fin;   // [RQ1] [RQ4]
   // zero next extension: next latch coincides with stage 8
   assign latch_fire = (s8_fire && nx_fin)                         // [RQ24]
                    || (step_reg == MS_NX && eob && go && nx_fin); // [RQ25]
   assign tx_dec     = step_reg == MS_S8 && eob && go;             // [RQ3]
   // the first whole beat of the next extension starts at stage 8 itself
   assign nx_dec     = s8_fire || (step_reg == MS_NX && eob && go); // [RQ3] [RQ25]

   always_comb begin
      step_next = step_reg;
      case (step_reg)
         MS_S7: begin
            if (s7_fire) begin
               step_next = MS_S8;
            end
         end
         MS_S8: begin
            if (s8_fire) begin
               step_next = nx_fin ? MS_S7 : MS_NX;
            end
         end
         MS_NX: begin
            if (latch_fire) begin
               step_next = MS_S7;
            end
         end
         default: begin
            step_next = MS_NX;
         end
      endcase
   end

   // whole-beat parts: value halved; odd tick is handled above
   phc_ext_counter #(
      .W (CNT_W)
   ) u_tx_cnt (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .ce         (ce),
      .load       (s7_fire), // [RQ3]
      .load_value (CNT_W'(time_extension >> 1)), // [RQ1] [RQ23]
      .dec        (tx_dec),
      .finished   (tx_fin)
   );

   // next extension is only even, so its low bit is ignored
   phc_ext_counter #(
      .W (CNT_W)
   ) u_nx_cnt (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .ce         (ce),
      .load       (s7_fire), // [RQ3]
      .load_value (CNT_W'(next_step_extension >> 1)), // [RQ23]
      .dec        (nx_dec),
      .finished   (nx_fin)
   );

   // ==========
   // fetch trap handling
   assign fe_fire = front_end_ready && eob && go;

   always_comb begin
      pend_next   = pend_reg;
      second_next = second_reg;
      take_next   = 1'b0;
      // each stage-2 retry re-latches the flag from the storage unit
      if (fe_fire) begin
         pend_next   = fetch_trap_flag && ctrl_reg[CTRL_TRAP_EN];  // [RQ20]
         second_next = fetch_trap_flag && trap_on_second_word;
      end
      // drained front end: only completed work remains ahead
      if (pend_reg && idle_microstep && eob && go) begin           // [RQ18] [RQ14]
         take_next   = trap_still_present;                         // [RQ16]
         pend_next   = 1'b0;
         second_next = 1'b0;
      end
      if (mispredict_recovery || fetch_pointer_jump_load) begin
         pend_next   = 1'b0;                                       // [RQ15] [RQ21]
         second_next = 1'b0;
         take_next   = 1'b0;
      end
      pass_next = !pend_next || address_pointer_word;              // [RQ13]
   end

   // ==========
   // stage enables
   always_comb begin
      en_next       = EN_NONE;
      en_next.s1    = fe_fire; // [RQ20]
      en_next.s2    = fe_fire; // [RQ20]
      en_next.s3    = fe_fire && !pend_reg; // [RQ19]
      en_next.s4    = fe_fire;
      en_next.s5    = fe_fire && !(pend_reg && second_reg); // [RQ19]
      en_next.s6    = fe_fire;
      en_next.s7    = s7_fire;
      en_next.s8    = s8_fire; // [RQ1]
      en_next.latch = latch_fire; // [RQ1] [RQ25]
   end

   // ==========
   // register bus slave
   assign do_write = awh_reg && wh_reg && !bv_reg;

   always_comb begin
      awh_next   = awh_reg;
      wh_next    = wh_reg;
      awa_next   = awa_reg;
      wd_next    = wd_reg;
      ws_next    = ws_reg;
      bv_next    = bv_reg;
      br_next    = br_reg;
      rv_next    = rv_reg;
      rd_next    = rd_reg;
      rr_next    = rr_reg;
      ctrl_next  = ctrl_reg;
      traps_next = traps_reg;
      if (s_axi_awvalid && s_axi_awready) begin
         awh_next = 1'b1;
         awa_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wh_next = 1'b1;
         wd_next = s_axi_wdata;
         ws_next = s_axi_wstrb;
      end
      if (do_write) begin
         awh_next = 1'b0;
         wh_next  = 1'b0;
         bv_next  = 1'b1;
         br_next  = mapped(awa_reg) ? RESP_OKAY : RESP_DECERR;
         if (awa_reg == REG_CTRL && ws_reg[0]) begin
            ctrl_next = wd_reg[1:0];
         end
         if (awa_reg == REG_TRAPS && ws_reg != '0) begin
            traps_next = '0;
         end
      end
      // a take in the clearing cycle still counts
      if (take_reg) begin
         traps_next = traps_next + 32'h1;
      end
      if (bv_reg && s_axi_bready) begin
         bv_next = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rv_next = 1'b1;
         rr_next = mapped(s_axi_araddr) ? RESP_OKAY : RESP_DECERR;
         case (s_axi_araddr)
            REG_CTRL:   rd_next = {30'h0, ctrl_reg};
            REG_STATUS: rd_next = {24'h0, ZERO_BYTE[7:7], step_reg,
                                   second_reg, pend_reg, phase_reg,
                                   nxf_reg, txf_reg};
            REG_TRAPS:  rd_next = traps_reg;
            default:    rd_next = 32'h0;
         endcase
      end else if (rv_reg && s_axi_rready) begin
         rv_next = 1'b0;
      end
   end

   // ==========
   // registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_reg   <= MS_NX;
         phase_reg  <= 1'b0;
         half_reg   <= 1'b0;                                       // [RQ26]
         en_reg     <= EN_NONE;
         eob_reg    <= 1'b0;
         txf_reg    <= 1'b1;
         nxf_reg    <= 1'b1;
         pend_reg   <= 1'b0;
         second_reg <= 1'b0;
         take_reg   <= 1'b0;
         pass_reg   <= 1'b1;
         ctrl_reg   <= CTRL_RESET;
         traps_reg  <= 32'h0;
         awh_reg    <= 1'b0;
         wh_reg     <= 1'b0;
         awa_reg    <= 8'h00;
         wd_reg     <= 32'h0;
         ws_reg     <= 4'h0;
         bv_reg     <= 1'b0;
         br_reg     <= RESP_OKAY;
         rv_reg     <= 1'b0;
         rd_reg     <= 32'h0;
         rr_reg     <= RESP_OKAY;
      end else if (ce) begin
         step_reg   <= step_next;
         phase_reg  <= phase_next;
         half_reg   <= half_next;
         en_reg     <= en_next;
         eob_reg    <= eob;
         txf_reg    <= tx_fin;                                     // [RQ27]
         nxf_reg    <= nx_fin;                                     // [RQ27]
         pend_reg   <= pend_next;
         second_reg <= second_next;
         take_reg   <= take_next;
         pass_reg   <= pass_next;
         ctrl_reg   <= ctrl_next;
         traps_reg  <= traps_next;
         awh_reg    <= awh_next;
         wh_reg     <= wh_next;
         awa_reg    <= awa_next;
         wd_reg     <= wd_next;
         ws_reg     <= ws_next;
         bv_reg     <= bv_next;
         br_reg     <= br_next;
         rv_reg     <= rv_next;
         rd_reg     <= rd_next;
         rr_reg     <= rr_next;
      end
   end

   // ==========
   // outputs
   assign stage_en           = en_reg;
   assign end_of_beat_enable = eob_reg;
   assign time_ext_finished  = txf_reg;
   assign next_ext_finished  = nxf_reg;
   assign fetch_trap_take    = take_reg;
   assign execute_pass_ok    = pass_reg;
   // ready flops: taken once, then closed until the response is gone
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_arready <= 1'b0;
      end else if (ce) begin
         s_axi_awready <= !awh_next && !bv_next && !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= !wh_next && !bv_next && !(s_axi_wvalid && s_axi_wready);
         s_axi_arready <= !rv_next && !(s_axi_arvalid && s_axi_arready);
      end
   end
   assign s_axi_bvalid = bv_reg;
   assign s_axi_bresp  = br_reg;
   assign s_axi_rvalid = rv_reg;
   assign s_axi_rdata  = rd_reg;
   assign s_axi_rresp  = rr_reg;
endmodule

// *** dv/phc_sva.sv ***
// checker for the pipeline hold and trap control ports
module phc_chk
   import phc_pkg::*;
(
   input wire logic            aclk,
   input wire logic            aresetn,
   input wire logic [TX_W-1:0] time_extension,
   input wire logic [NX_W-1:0] next_step_extension,
   input wire logic            storage_hold_request,
   input wire logic            fetch_trap_flag,
   input wire logic            mispredict_recovery,
   input wire logic            idle_microstep,
   input wire logic            trap_still_present,
   input wire logic            fetch_pointer_jump_load,
   input wire phc_stage_en_s   stage_en,
   input wire logic            end_of_beat_enable,
   input wire logic            time_ext_finished,
   input wire logic            next_ext_finished,
   input wire logic            fetch_trap_take
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ==========
   // step timing
   chk_reset_clear: assert property (
      $rose(aresetn) |-> stage_en == EN_NONE && time_ext_finished && next_ext_finished)
      else $error("outputs not cleared by reset");
   chk_beat_period: assert property (
      end_of_beat_enable |=> !end_of_beat_enable ##[1:2] end_of_beat_enable)
      else $error("end of beat spacing wrong");
   chk_tx_zero: assert property (
      stage_en.s7 && $past(time_extension) == 3'h0 && $past(next_step_extension) < 4'h2
      ##1 !storage_hold_request |=> stage_en.s8 && stage_en.latch)
      else $error("stage 8 or latch late without extension");
   chk_tx_even: assert property (
      stage_en.s7 && $past(time_extension) == 3'h2 |=> !stage_en.s8 [*3])
      else $error("even extension did not delay stage 8");
   chk_tx_odd: assert property (
      stage_en.s7 && $past(time_extension) == 3'h1 ##1 !storage_hold_request [*2]
      |-> !stage_en.s8 ##1 stage_en.s8)
      else $error("odd extension not one tick");
   // ==========
   // holds and traps
   chk_hold_blocks: assert property (
      storage_hold_request |=> stage_en == EN_NONE)
      else $error("stage enable during hold");
   chk_take_idle: assert property (
      fetch_trap_take |-> $past(idle_microstep) && $past(trap_still_present)
      && !$past(storage_hold_request))
      else $error("trap taken outside idle step");
   chk_mispredict_wins: assert property (
      mispredict_recovery |=> !fetch_trap_take)
      else $error("trap taken during mispredict recovery");
   chk_trap_s3: assert property (
      $past(fetch_trap_flag) && stage_en.s2 ##0 (fetch_trap_flag && !mispredict_recovery
      && !fetch_pointer_jump_load && !fetch_trap_take) [*2] |=> !stage_en.s3 || fetch_trap_take)
      else $error("stage 3 ran with a pending trap");
   cover property (stage_en.s7 && $past(time_extension) == 3'h2);
   cover property (fetch_trap_take);
   cover property (storage_hold_request && end_of_beat_enable);
endmodule

bind phc_top phc_chk u_chk (.aclk, .aresetn, .time_extension, .next_step_extension,
   .storage_hold_request, .fetch_trap_flag, .mispredict_recovery, .idle_microstep,
   .trap_still_present, .fetch_pointer_jump_load, .stage_en, .end_of_beat_enable,
   .time_ext_finished, .next_ext_finished, .fetch_trap_take);

// *** dv/phc_su_model.sv ***
// storage unit model: hold request and fetch trap flag
module phc_su_model
   import phc_pkg::*;
(
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire phc_stage_en_s stage_en,
   input  wire logic          memctl_busy,
   input  wire logic          bad_fetch,
   output logic               storage_hold_request,
   output logic               fetch_trap_flag
);
   logic hold_reg, hold_next, trap_reg, trap_next;
   always_comb begin
      hold_next = hold_reg;
      trap_next = trap_reg;
      if (stage_en.s7 && memctl_busy) hold_next = 1'b1;
      if (!memctl_busy) hold_next = 1'b0;
      // flag rises only at stage 2; a reloaded fetch pointer drops it at once
      if (stage_en.s2 || !bad_fetch) trap_next = bad_fetch;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_reg <= 1'b0;
         trap_reg <= 1'b0;
      end else begin
         hold_reg <= hold_next;
         trap_reg <= trap_next;
      end
   end
   assign storage_hold_request = hold_reg;
   assign fetch_trap_flag = trap_reg;
endmodule

// *** dv/phc_top_test.sv ***
// self-checking bench of the pipeline hold and trap control
module phc_top_test import phc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // signals
   logic            aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, front_end_ready = 1'b1;
   logic            address_pointer_word = 1'b0, trap_on_second_word = 1'b0;
   logic            mispredict_recovery = 1'b0, idle_microstep = 1'b0;
   logic            trap_still_present = 1'b1, fetch_pointer_jump_load = 1'b0;
   logic            memctl_busy = 1'b0, bad_fetch = 1'b0;
   logic [TX_W-1:0] time_extension = '0;
   logic [NX_W-1:0] next_step_extension = '0;
   logic [7:0]      s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0]     s_axi_wdata = '0, s_axi_rdata;
   logic [3:0]      s_axi_wstrb = '0;
   logic            s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic            s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]      s_axi_bresp, s_axi_rresp;
   logic            storage_hold_request, fetch_trap_flag, end_of_beat_enable;
   logic            time_ext_finished, next_ext_finished, fetch_trap_take, execute_pass_ok;
   phc_stage_en_s   stage_en;
   int              error_cnt = 0, checks_done = 0, cyc = 0, seed, traps_exp = 0;
   int              gaps[$];
   always #5 aclk = ~aclk;
   phc_top dut (.aclk, .aresetn, .ce, .time_extension, .next_step_extension,
      .storage_hold_request, .front_end_ready, .fetch_trap_flag, .trap_on_second_word,
      .address_pointer_word, .mispredict_recovery, .idle_microstep, .trap_still_present,
      .fetch_pointer_jump_load, .stage_en, .end_of_beat_enable, .time_ext_finished,
      .next_ext_finished, .fetch_trap_take, .execute_pass_ok, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   phc_su_model u_su (.aclk, .aresetn, .stage_en, .memctl_busy, .bad_fetch,
      .storage_hold_request, .fetch_trap_flag);
   // ==========
   // checking and bus tasks
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic cmp_val(input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %0t exp %0h got %0h", $time, e, g);
      end
   endtask
   task automatic cmp_resp(input logic [1:0] e, input logic [1:0] g);
      checks_done++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %0t resp exp %0h got %0h", $time, e, g);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
      do begin
         @(posedge aclk);
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic reg_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
      end while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do begin
         @(posedge aclk);
      end while (s_axi_rvalid !== 1'b1);
      cmp_val(e, s_axi_rdata);
      cmp_resp(er, s_axi_rresp);
      s_axi_rready <= 1'b0;
   endtask
   task automatic wait_bit(input int b, output int c);
      c = 0;
      while (stage_en[b] !== 1'b1 && c < 60) begin
         @(posedge aclk);
         c++;
      end
   endtask
   task automatic count_en(input logic [8:0] m, input int n, output int k);
      k = 0;
      repeat (n) begin
         @(posedge aclk);
         if ((stage_en & m) != 9'h000) k++;
      end
   endtask
   // ==========
   // main sequence
   initial begin
      logic [1:0] r;
      int         c, k, tx, nx, n_take;
      seed = 32'h092786C0;
      tick(5);
      cmp_val(32'h6, {20'h0, stage_en, time_ext_finished, next_ext_finished,
                      fetch_trap_take});
      aresetn <= 1'b1;
      tick(1);
      $display("reset test done");
      reg_chk(REG_CTRL, {30'h0, CTRL_RESET}, RESP_OKAY);
      reg_chk(REG_TRAPS, 32'h0, RESP_OKAY);
      reg_chk(8'h0C, 32'h0, RESP_DECERR);
      axi_wr(8'h0C, 32'hFFFFFFFF, r);
      cmp_resp(RESP_DECERR, r);
      axi_wr(REG_CTRL, 32'h0, r);
      reg_chk(REG_CTRL, 32'h0, RESP_OKAY);
      axi_wr(REG_CTRL, 32'h1, r);
      $display("register test done");
      for (tx = 0; tx < 7; tx++) begin
         nx = 2 * ($unsigned($random(seed)) % 5);
         wait_bit(8, c);
         time_extension <= tx[TX_W-1:0];
         next_step_extension <= nx[NX_W-1:0];
         gaps.push_back(2);
         gaps.push_back(1 + tx);
         gaps.push_back(nx);
         wait_bit(6, c);
         cmp_val(gaps.pop_front(), c);
         tick(1);
         cmp_val(tx < 2, time_ext_finished);
         wait_bit(7, c);
         cmp_val(gaps.pop_front(), c);
         wait_bit(8, c);
         cmp_val(gaps.pop_front(), c);
      end
      $display("step timing test done");
      wait_bit(8, c);
      memctl_busy <= 1'b1;
      wait_bit(6, c);
      tick(2);
      count_en(9'h1FF, 10, k);
      cmp_val(0, k);
      memctl_busy <= 1'b0;
      count_en(9'h1FF, 10, k);
      cmp_val(1, k > 0);
      $display("hold test done");
      for (int m = 0; m < 4; m++) begin
         trap_on_second_word <= m[0];
         bad_fetch <= 1'b1;
         tick(6);
         count_en(m[0] ? 9'h014 : 9'h004, 10, k);
         cmp_val(0, k);
         count_en(9'h003, 6, k);
         cmp_val(1, k > 0);
         cmp_val(0, execute_pass_ok);
         n_take = 0;
         for (int i = 0; i < 24; i++) begin
            @(posedge aclk);
            if (fetch_trap_take === 1'b1) begin
               n_take++;
               idle_microstep <= 1'b0;
               bad_fetch <= 1'b0;
            end
            if (i == 0) bad_fetch <= (m < 2);
            if (i == 1) begin
               idle_microstep <= 1'b1;
               trap_still_present <= (m != 1);
               mispredict_recovery <= (m == 2);
               fetch_pointer_jump_load <= (m == 3);
            end
            if (i == 4) begin
               mispredict_recovery <= 1'b0;
               fetch_pointer_jump_load <= 1'b0;
            end
         end
         cmp_val(m == 0, n_take);
         traps_exp += (m == 0);
         bad_fetch <= 1'b0;
         idle_microstep <= 1'b0;
         trap_still_present <= 1'b1;
         tick(2);
         fetch_pointer_jump_load <= 1'b1;
         tick(3);
         fetch_pointer_jump_load <= 1'b0;
         tick(4);
      end
      reg_chk(REG_TRAPS, traps_exp, RESP_OKAY);
      axi_wr(REG_TRAPS, 32'h0, r);
      reg_chk(REG_TRAPS, 32'h0, RESP_OKAY);
      $display("trap test done");
      aresetn <= 1'b0;
      tick(2);
      cmp_val(32'h6, {20'h0, stage_en, time_ext_finished, next_ext_finished,
                      fetch_trap_take});
      $display("second reset test done");
      close_out();
   end
endmodule
